// ==== logic/sleep_ctrl_pkg.sv ====
// Purpose: Shared constants and types of the sleep and interrupt sequencer.
// Assumes: One clock; sleep and interrupt come from logic on that clock.
// Notes: Every instruction is a fetch cycle followed by an execute cycle.

package sleep_ctrl_pkg;

  localparam int ADDR_W_DEF = 12;
  localparam int STROBE_N_DEF = 3;
  localparam logic [11:0] INT_VECTOR_DEF = 12'h3ff;
  localparam int STB_WRITE = 0;
  localparam int STB_K_WRITE = 1;
  localparam int STB_READ = 2;
  localparam logic [0:0] PC_STEP = 1'h1;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_EXEC,
    ST_SLEEP
  } seq_state_t;

endpackage : sleep_ctrl_pkg

// ==== logic/strobe_gate.sv ====
// Purpose: Turns strobe requests of the execute cycle into one-cycle pulses.
// Assumes: fire_in is high for exactly one cycle per instruction.
// Notes: Requests outside an execute cycle never reach the outputs.

module strobe_gate
  import sleep_ctrl_pkg::*;
#(
  parameter int STROBE_N = STROBE_N_DEF
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic fire_in,
  input wire logic [STROBE_N-1:0] strobe_req_in,
  output logic [STROBE_N-1:0] strobe_out
);

  typedef struct packed {
    logic [STROBE_N-1:0] strobe;
  } gate_t;

  gate_t s;
  gate_t next_s;

  if (STROBE_N < 1) begin : g_check
    $error("strobe_gate needs at least one strobe");
  end

  always_comb begin
    next_s = s;
    next_s.strobe = fire_in ? strobe_req_in : '0;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign strobe_out = s.strobe;

endmodule : strobe_gate

// ==== logic/int_context_store.sv ====
// Purpose: Holds the return location and flags while the service_routine runs.
// Assumes: Only one interrupt is serviced at a time.
// Notes: A save overwrites the previous context.

module int_context_store
  import sleep_ctrl_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic save_in,
  input wire logic [ADDR_W-1:0] save_pc_in,
  input wire logic save_zero_in,
  input wire logic save_carry_in,
  output logic [ADDR_W-1:0] saved_pc_out,
  output logic saved_zero_out,
  output logic saved_carry_out
);

  typedef struct packed {
    logic [ADDR_W-1:0] pc;
    logic zero;
    logic carry;
  } ctx_t;

  ctx_t s;
  ctx_t next_s;

  if (ADDR_W < 1) begin : g_check
    $error("int_context_store needs an address width of at least one");
  end

  always_comb begin
    next_s = s;
    if (save_in) begin
      next_s.pc = save_pc_in;
      next_s.zero = save_zero_in;
      next_s.carry = save_carry_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign saved_pc_out = s.pc;
  assign saved_zero_out = s.zero;
  assign saved_carry_out = s.carry;

endmodule : int_context_store

// ==== logic/core_sleep_interrupt_control.sv ====
// Purpose: Fetch, execute, sleep and interrupt sequencing of a small core.
// Assumes: The datapath decodes the instruction while exec_valid_out is high
//   and reports jumps, strobes, flag values and interrupt instructions then.
// Notes: Sleep and interrupt are synchronous to core_clk_in.

module core_sleep_interrupt_control
  import sleep_ctrl_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int STROBE_N = STROBE_N_DEF,
  parameter logic [ADDR_W-1:0] INT_VECTOR = ADDR_W'(INT_VECTOR_DEF)
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic sleep_in,
  input wire logic interrupt_in,
  input wire logic pc_load_in,
  input wire logic [ADDR_W-1:0] pc_target_in,
  input wire logic [STROBE_N-1:0] strobe_req_in,
  input wire logic int_enable_set_in,
  input wire logic int_enable_clr_in,
  input wire logic int_return_in,
  input wire logic int_return_enable_in,
  input wire logic flag_zero_in,
  input wire logic flag_carry_in,
  output logic [ADDR_W-1:0] address_out,
  output logic mem_enable_out,
  output logic exec_valid_out,
  output logic [STROBE_N-1:0] strobe_out,
  output logic interrupt_ack_out,
  output logic int_enabled_out,
  output logic sleeping_out,
  output logic flag_restore_out,
  output logic restore_zero_out,
  output logic restore_carry_out
);

  typedef struct packed {
    seq_state_t st;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] addr;
    logic mem_en;
    logic exec;
    logic ie;
    logic ack;
    logic sleeping;
    logic restore;
  } seq_t;

  seq_t s;
  seq_t next_s;
  logic save_ctx;
  logic [ADDR_W-1:0] save_pc;
  logic [ADDR_W-1:0] saved_pc;
  logic [ADDR_W-1:0] next_pc;

  if (ADDR_W < 2 || ADDR_W > 16) begin : g_check_addr
    $error("ADDR_W must lie between 2 and 16");
  end
  if (STROBE_N < 1) begin : g_check_stb
    $error("STROBE_N must be at least one");
  end

  // An interrupt request counts only while interrupts are enabled.
  function automatic logic irq_taken(input logic enabled, input logic req);
    return enabled && req;
  endfunction : irq_taken

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.exec = 1'b0;
    next_s.restore = 1'b0;
    save_ctx = 1'b0;
    save_pc = s.pc;
    next_pc = s.pc + ADDR_W'(PC_STEP);
    unique case (s.st)
      ST_FETCH: begin
        // Memory is read on the edge that leaves this state.
        next_s.mem_en = 1'b0;
        next_s.st = ST_EXEC;
        next_s.exec = 1'b1;
      end
      ST_EXEC: begin
        if (int_return_in) begin
          next_pc = saved_pc;
          next_s.restore = 1'b1;
          next_s.ie = int_return_enable_in;
        end else if (pc_load_in) begin
          next_pc = pc_target_in;
        end
        if (int_enable_set_in) begin
          next_s.ie = 1'b1;
        end
        if (int_enable_clr_in) begin
          next_s.ie = 1'b0;
        end
        next_s.pc = next_pc;
        if (sleep_in) begin
          // Boundary sample: the fetched instruction has now executed.
          next_s.st = ST_SLEEP;
          next_s.sleeping = 1'b1;
          next_s.mem_en = 1'b0;
        end else if (irq_taken(s.ie, interrupt_in)) begin
          // Sampled once per two-cycle instruction.
          save_ctx = 1'b1;
          save_pc = next_pc;
          next_s.pc = INT_VECTOR;
          next_s.addr = INT_VECTOR;
          next_s.ie = 1'b0;
          next_s.ack = 1'b1;
          next_s.mem_en = 1'b1;
          next_s.st = ST_FETCH;
        end else begin
          next_s.addr = next_pc;
          next_s.mem_en = 1'b1;
          next_s.st = ST_FETCH;
        end
      end
      ST_SLEEP: begin
        // Sleep is watched, and interrupt only in the wake cycle; reset acts through the flop reset.
        next_s.mem_en = 1'b0;
        if (!sleep_in) begin
          next_s.sleeping = 1'b0;
          next_s.mem_en = 1'b1;
          next_s.st = ST_FETCH;
          if (irq_taken(s.ie, interrupt_in)) begin
            save_ctx = 1'b1;
            save_pc = s.pc;
            next_s.pc = INT_VECTOR;
            next_s.addr = INT_VECTOR;
            next_s.ie = 1'b0;
            next_s.ack = 1'b1;
          end else begin
            next_s.addr = s.pc;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      // Reset is honoured in every state, sleep included.
      s <= '{st: ST_FETCH, pc: '0, addr: '0, mem_en: 1'b1, exec: 1'b0,
             ie: 1'b0, ack: 1'b0, sleeping: 1'b0, restore: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  strobe_gate #(
    .STROBE_N(STROBE_N)
  ) u_strobe_gate (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .fire_in(s.exec),
    .strobe_req_in(strobe_req_in),
    .strobe_out(strobe_out)
  );

  int_context_store #(
    .ADDR_W(ADDR_W)
  ) u_int_context_store (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .save_in(save_ctx),
    .save_pc_in(save_pc),
    .save_zero_in(flag_zero_in),
    .save_carry_in(flag_carry_in),
    .saved_pc_out(saved_pc),
    .saved_zero_out(restore_zero_out),
    .saved_carry_out(restore_carry_out)
  );

  assign address_out = s.addr;
  assign mem_enable_out = s.mem_en;
  assign exec_valid_out = s.exec;
  assign interrupt_ack_out = s.ack;
  assign int_enabled_out = s.ie;
  assign sleeping_out = s.sleeping;
  assign flag_restore_out = s.restore;

endmodule : core_sleep_interrupt_control

// ==== sim/core_sleep_interrupt_control_assertions.sv ====
// Purpose: Port timing checks of the sleep and interrupt sequencer.
// Assumes: Bound to every instance of the top module.
// Notes: Strobes of the last executed instruction may show in sleep once.
module sleep_ctrl_checker
  import sleep_ctrl_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int STROBE_N = STROBE_N_DEF,
  parameter logic [ADDR_W-1:0] INT_VECTOR = '1
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic sleep_in,
  input wire logic interrupt_in,
  input wire logic [ADDR_W-1:0] address_out,
  input wire logic mem_enable_out,
  input wire logic exec_valid_out,
  input wire logic [STROBE_N-1:0] strobe_out,
  input wire logic interrupt_ack_out,
  input wire logic int_enabled_out,
  input wire logic sleeping_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_mem_off; sleeping_out |-> !mem_enable_out; endproperty
  a_mem_off: assert property (p_mem_off)
    else $error("memory enabled in sleep");
  property p_quiet;
    sleeping_out && $past(sleeping_out) |-> strobe_out == '0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("strobe active in sleep");
  property p_enter; exec_valid_out && sleep_in |=> sleeping_out; endproperty
  a_enter: assert property (p_enter)
    else $error("sleep not entered after instruction");
  property p_fetch; mem_enable_out && sleep_in |=> exec_valid_out; endproperty
  a_fetch: assert property (p_fetch)
    else $error("sleep taken inside an instruction");
  property p_exit;
    sleeping_out && !sleep_in |=> mem_enable_out ##1 exec_valid_out;
  endproperty
  a_exit: assert property (p_exit)
    else $error("wake not two cycles");
  property p_hold;
    sleeping_out && sleep_in |=>
      sleeping_out && $stable(address_out) && !interrupt_ack_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("sleep state disturbed");
  property p_pulse;
    |strobe_out |-> $past(exec_valid_out) ##1 strobe_out == '0;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe not a single pulse");
  property p_take;
    exec_valid_out && !sleep_in && interrupt_in && int_enabled_out |=>
      interrupt_ack_out && address_out == INT_VECTOR;
  endproperty
  a_take: assert property (p_take)
    else $error("interrupt not taken to vector");
  property p_masked; !int_enabled_out |=> !interrupt_ack_out; endproperty
  a_masked: assert property (p_masked)
    else $error("interrupt taken while disabled");
  property p_fetch_int; mem_enable_out |=> !interrupt_ack_out; endproperty
  a_fetch_int: assert property (p_fetch_int)
    else $error("interrupt sampled in a fetch cycle");
  property p_instr; exec_valid_out |=> mem_enable_out || sleeping_out;
  endproperty
  a_instr: assert property (p_instr)
    else $error("execute not followed by fetch");
endmodule : sleep_ctrl_checker
bind core_sleep_interrupt_control sleep_ctrl_checker #(.ADDR_W(ADDR_W),
  .STROBE_N(STROBE_N), .INT_VECTOR(INT_VECTOR)) sleep_ctrl_checker_inst (
  .core_clk_in, .sys_rst_in, .sleep_in, .interrupt_in, .address_out,
  .mem_enable_out, .exec_valid_out, .strobe_out, .interrupt_ack_out,
  .int_enabled_out, .sleeping_out);

// ==== sim/prog_mem_model.sv ====
// Purpose: Program memory and decoder standing beside the sequencer.
// Assumes: Word held while disabled; word value is its address.
// Notes: Address 1 enables interrupts, 3ff returns from the routine.
module prog_mem_model (
  input wire logic core_clk_in,
  input wire logic mem_en_in,
  input wire logic [11:0] addr_in,
  output logic [2:0] strobe_req_out,
  output logic ie_set_out,
  output logic ret_out,
  output logic zero_out,
  output logic carry_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] word = 12'h000;
  always_ff @(posedge core_clk_in) if (mem_en_in) word <= addr_in;
  assign strobe_req_out = word[2:0];
  assign ie_set_out = word == 12'h001;
  assign ret_out = word == 12'h3ff;
  assign zero_out = word[0];
  assign carry_out = word[1];
endmodule : prog_mem_model

// ==== sim/tb_core_sleep_interrupt_control.sv ====
// Purpose: Scenario bench of the sleep and interrupt sequencer.
// Assumes: Default parameters; inputs change on the falling edge.
// Notes: Each scenario task, t_run to t_reset, drives one scenario and judges it; cmp, tick and wait_ev are helpers.
module tb_core_sleep_interrupt_control import sleep_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, slp = 1'b0, irq = 1'b0;
  logic [11:0] addr;
  logic [2:0] stb, sreq;
  logic men, ev, ack, ie, sl, frs, rz, rc, ies, ret, fz, fc;
  int n_mismatch = 0, checks = 0, cyc = 0;
  core_sleep_interrupt_control core_sleep_interrupt_control_inst (
    .core_clk_in(clk), .sys_rst_in(rst), .sleep_in(slp),
    .interrupt_in(irq), .pc_load_in(1'b0), .pc_target_in(12'h000),
    .strobe_req_in(sreq), .int_enable_set_in(ies),
    .int_enable_clr_in(1'b0), .int_return_in(ret),
    .int_return_enable_in(1'b1), .flag_zero_in(fz), .flag_carry_in(fc),
    .address_out(addr), .mem_enable_out(men), .exec_valid_out(ev),
    .strobe_out(stb), .interrupt_ack_out(ack), .int_enabled_out(ie),
    .sleeping_out(sl), .flag_restore_out(frs), .restore_zero_out(rz),
    .restore_carry_out(rc));
  prog_mem_model prog_mem_model_inst (.core_clk_in(clk), .mem_en_in(men),
    .addr_in(addr), .strobe_req_out(sreq), .ie_set_out(ies),
    .ret_out(ret), .zero_out(fz), .carry_out(fc));
  initial forever #12.5 clk = ~clk;
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wait_ev();
    for (int i = 0; i < 20 && ev !== 1'b1; i++) tick(1);
  endtask : wait_ev
  task automatic t_run();
    logic [11:0] a;
    repeat (3) begin
      wait_ev();
      a = addr;
      irq = !ie;
      tick(1);
      irq = 1'b0;
      cmp({men, stb}, {9'h001, a[2:0]});
      cmp(addr, a + 12'h001);
      cmp(12'(ack), 12'h000);
    end
  endtask : t_run
  task automatic t_sleep();
    logic [11:0] a;
    wait_ev();
    a = addr;
    slp = 1'b1;
    tick(1);
    cmp({sl, stb}, {9'h001, a[2:0]});
    irq = 1'b1;
    repeat (4) begin
      tick(1);
      cmp({men, stb, ack}, 12'h000);
      cmp(addr, a);
    end
    slp = 1'b0;
    irq = 1'b0;
    tick(1);
    cmp({men, sl}, 12'h002);
    cmp(addr, a + 12'h001);
    tick(1);
    cmp(12'(ev), 12'h001);
  endtask : t_sleep
  task automatic t_pattern(input int n);
    logic [11:0] a;
    int e;
    int w;
    e = 0;
    w = 0;
    slp = 1'b1;
    tick(4);
    a = addr;
    for (int i = 0; i < 4 * (n + 1); i++) begin
      slp = (i % (n + 1)) != 0;
      tick(1);
      e += int'(ev);
      w += int'(stb[0]);
    end
    cmp(12'(e), 12'h004);
    cmp(12'(w), 12'h002);
    cmp(addr, a + 12'h004);
  endtask : t_pattern
  task automatic t_int();
    logic [11:0] a;
    logic z, c;
    a = addr + 12'h001;
    z = fz;
    c = fc;
    slp = 1'b0;
    irq = 1'b1;
    tick(1);
    irq = 1'b0;
    cmp({ack, men}, 12'h003);
    cmp(addr, INT_VECTOR_DEF);
    wait_ev();
    tick(1);
    cmp(addr, a);
    cmp({frs, rz, rc}, {9'h001, z, c});
    irq = 1'b1;
    tick(1);
    irq = 1'b0;
    cmp({ack, ev}, 12'h001);
    a = addr + 12'h001;
    z = fz;
    c = fc;
    irq = 1'b1;
    tick(1);
    irq = 1'b0;
    cmp({ack, ie}, 12'h002);
    wait_ev();
    tick(1);
    cmp(addr, a);
    cmp({frs, rz, rc}, {9'h001, z, c});
  endtask : t_int
  task automatic t_reset();
    slp = 1'b1;
    tick(6);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    cmp({addr[10:0], sl}, 12'h000);
  endtask : t_reset
  initial begin
    tick(3);
    rst = 1'b0;
    t_run();
    t_sleep();
    t_pattern(2);
    t_pattern(3);
    t_pattern(7);
    t_int();
    t_reset();
    tally_and_finish();
  end
endmodule : tb_core_sleep_interrupt_control
